// ### thermal_throttle_pin_monitor.sv
// Purpose: throttle pin select, assertion timer, limit flag, fan
//          full-speed override and over-temperature pin drive
// Assumes: inputs synchronous to CORE_CLK_I except the pin inputs
// Notes:   register read data appears one cycle after the strobe
`timescale 1ns/10ps
// Operation
// [RL1] throttle function sits on one pin only, chosen by select bit
// [RL2] full-speed bit forces running fans to full duty while pin held low
// [RL3] only fans already running are forced; stopped fans unchanged
// [RL4] full-speed bit clear leaves fan settings untouched
// [RL5] timer counts while asserted, pauses on release, then resumes
// [RL6] timer saturates at full scale until cleared
// [RL7] first assertion after clear sets timer bit 0 at once
// [RL8] past two ticks timer becomes 2; bit 0 then weighs one tick
// [RL9] reading the timer returns it and clears it
// [RL10] read during assertion clears, sets bit 0 again, keeps counting
// [RL11] read during assertion with limit zero sets the flag again
// [RL12] host-writable 8-bit limit register
// [RL13] timer above limit sets status flag and raises alert
// [RL14] mask bit blocks alert, flag still set
// [RL15] limit 0 alerts on first assertion, limit 1 after two ticks
// [RL16] host clears flag by reading status after timer read
// [RL17] enabled channel above critical by a quarter degree drives pin low
// [RL18] pin held low until a later measurement is at or below limit
// [RL19] three critical-limit registers: remote 1, local, remote 2
// [RL20] bit 3 of each channel config enables pin drive
// [RL21] config four bit 0 turns aux pin into open-drain alert
// [RL22] flag sticky; cleared by status read once cause is gone
// [RL23] alert stays while unmasked flag remains set
// [RL24] pin input synchronised and own drive excluded
// [RL25] prescaler gives one tick per 22.76 ms of assertion
module thermal_throttle_pin_monitor
    import throttle_monitor_pkg::*;
#(
    parameter int TICK_CYC = throttle_monitor_pkg::TICK_CYCLES
) (
    // clock and reset
    input  wire logic                             CORE_CLK_I,
    input  wire logic                             RST_I,
    // register port
    input  wire throttle_monitor_pkg::reg_req_t   REG_REQ_I,
    output      logic [7:0]                       REG_RDATA_O,
    // throttle pins: fan-tach-shared (a) and alternate (b)
    input  wire logic                             PIN_A_I,
    output      logic                             PIN_A_O,
    output      logic                             PIN_A_OE_O,
    input  wire logic                             PIN_B_I,
    output      logic                             PIN_B_O,
    output      logic                             PIN_B_OE_O,
    // aux pin used as alert
    output      logic                             AUX_PIN_O,
    output      logic                             AUX_PIN_OE_O,
    output      logic                             ALERT_N_O,
    // temperature measurements: remote 1, local, remote 2
    input  wire throttle_monitor_pkg::temp_meas_t [2:0] TEMP_I,
    // fans
    input  wire throttle_monitor_pkg::fan_ctrl_t  [2:0] FAN_I,
    output      logic [2:0][7:0]                  FAN_DUTY_O,
    output      logic                             FLAG_O
);
    import throttle_monitor_pkg::*;

    localparam int PW = $clog2(TICK_CYC);

    if (TICK_CYC < 2) begin : g_bad_tick
        $error("TICK_CYC must be at least 2");
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0][7:0] cfg;
        logic [2:0][7:0] crit;
        logic [7:0]      mask2;
        logic [7:0]      cfg3;
        logic [7:0]      cfg4;
        logic [7:0]      limit;
        logic [7:0]      timer;
        phase_t          phase;
        logic [PW-1:0]   presc;
        logic            flag;
        logic [2:0]      hot;
        logic            drive;
        logic [1:0]      drive_hist;
        logic            sync1;
        logic            sync2;
        logic [2:0][7:0] duty;
        logic [7:0]      rdata;
    } state_t;

    state_t s_q;
    state_t s_d;
    logic   ext;
    logic   tick;
    logic   rd_timer;
    logic   rd_status;
    logic   over;
    logic   full_speed_on_throttle;
    logic [2:0] running;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        // pin mux ahead of the synchroniser
        s_d.sync1 = s_q.cfg4[BIT_PIN_SELECT] ? ~PIN_B_I : ~PIN_A_I;
        s_d.sync2 = s_q.sync1;                            // see [RL24]
        s_d.drive_hist = {s_q.drive_hist[0], s_q.drive};
        // own drive masked until it has left the synchroniser
        ext = s_q.sync2 & s_q.cfg3[BIT_THR_EN] & ~s_q.drive
              & ~(|s_q.drive_hist);                       // see [RL24]
        rd_timer  = REG_REQ_I.rd && (REG_REQ_I.addr == OFS_TIMER);
        rd_status = REG_REQ_I.rd && (REG_REQ_I.addr == OFS_STATUS2);

        // register writes
        if (REG_REQ_I.wr) begin
            case (REG_REQ_I.addr)
                OFS_CFG_R1:   s_d.cfg[0]  = REG_REQ_I.wdata;
                OFS_CFG_LOC:  s_d.cfg[1]  = REG_REQ_I.wdata;
                OFS_CFG_R2:   s_d.cfg[2]  = REG_REQ_I.wdata;
                OFS_CRIT_R1:  s_d.crit[0] = REG_REQ_I.wdata; // see [RL19]
                OFS_CRIT_LOC: s_d.crit[1] = REG_REQ_I.wdata;
                OFS_CRIT_R2:  s_d.crit[2] = REG_REQ_I.wdata;
                OFS_MASK2:    s_d.mask2   = REG_REQ_I.wdata;
                OFS_CFG3:     s_d.cfg3    = REG_REQ_I.wdata;
                OFS_CFG4:     s_d.cfg4    = REG_REQ_I.wdata;
                OFS_LIMIT:    s_d.limit   = REG_REQ_I.wdata; // see [RL12]
                default:      s_d.rdata   = s_q.rdata;
            endcase
        end

        // register reads; unmapped offsets read zero
        if (REG_REQ_I.rd) begin
            case (REG_REQ_I.addr)
                OFS_CFG_R1:   s_d.rdata = s_q.cfg[0];
                OFS_CFG_LOC:  s_d.rdata = s_q.cfg[1];
                OFS_CFG_R2:   s_d.rdata = s_q.cfg[2];
                OFS_CRIT_R1:  s_d.rdata = s_q.crit[0];
                OFS_CRIT_LOC: s_d.rdata = s_q.crit[1];
                OFS_CRIT_R2:  s_d.rdata = s_q.crit[2];
                OFS_STATUS2:  s_d.rdata = {2'b00, s_q.flag, 5'b00000};
                OFS_MASK2:    s_d.rdata = s_q.mask2;
                OFS_CFG3:     s_d.rdata = s_q.cfg3;
                OFS_TIMER:    s_d.rdata = s_q.timer;
                OFS_LIMIT:    s_d.rdata = s_q.limit;
                OFS_CFG4:     s_d.rdata = s_q.cfg4;
                default:      s_d.rdata = RST_ZERO;
            endcase
        end

        // prescaler runs only while asserted
        tick = ext && (s_q.presc == PW'(TICK_CYC - 1));   // see [RL25]
        if (ext) begin
            s_d.presc = tick ? '0 : s_q.presc + 1'b1;     // see [RL5]
        end

        // assertion timer
        if (rd_timer) begin
            s_d.timer = RST_ZERO;                         // see [RL9]
            s_d.phase = PH_EMPTY;
            s_d.presc = '0;
            if (ext) begin
                s_d.timer = TIMER_FIRST;                  // see [RL10]
                s_d.phase = PH_FIRST;
            end
        end else begin
            case (s_q.phase)
                PH_EMPTY: begin
                    if (ext) begin
                        s_d.timer = TIMER_FIRST;          // see [RL7]
                        s_d.phase = PH_FIRST;
                    end
                end
                PH_FIRST: begin
                    if (tick) begin
                        s_d.phase = PH_HALF;
                    end
                end
                PH_HALF: begin
                    if (tick) begin
                        s_d.timer = TIMER_SECOND;         // see [RL8]
                        s_d.phase = PH_RUN;
                    end
                end
                PH_RUN: begin
                    if (tick && s_q.timer != TIMER_FULL) begin
                        s_d.timer = s_q.timer + 8'h01;    // see [RL6]
                    end
                end
                default: begin
                    s_d.phase = PH_EMPTY;
                end
            endcase
        end

        // sticky flag: a new cause beats the clearing read
        over = s_q.cfg3[BIT_THR_EN]
               && (s_q.timer > s_q.limit);               // see [RL11] [RL15]
        s_d.flag = over | (s_q.flag & ~rd_status);  // see [RL13] [RL22]

        // over-temperature drive, changed by fresh measurements, by clearing a channel's pin enable, or by setting or clearing the throttle enable
        for (int i = 0; i < 3; i++) begin
            if (!s_q.cfg[i][BIT_PIN_OUT_EN]) begin
                s_d.hot[i] = 1'b0;                        // see [RL20]
            end else if (TEMP_I[i].valid) begin
                s_d.hot[i] = TEMP_I[i].value >
                             {s_q.crit[i], 2'b00};        // see [RL17]
            end
        end
        s_d.drive = (|s_d.hot) & s_q.cfg3[BIT_THR_EN];   // see [RL18]

        // fan override
        full_speed_on_throttle = s_q.cfg3[BIT_FULL_SPEED] && ext;
        for (int i = 0; i < 3; i++) begin
            running[i] = FAN_I[i].auto_mode ? FAN_I[i].above_start
                         : (FAN_I[i].duty != DUTY_OFF);   // see [RL3]
            s_d.duty[i] = (full_speed_on_throttle && running[i]) ? DUTY_FULL
                          : FAN_I[i].duty;          // see [RL2] [RL4]
        end
    end

    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            s_q            <= '0;
            s_q.cfg3       <= RST_CFG3;
            s_q.phase      <= PH_EMPTY;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign REG_RDATA_O  = s_q.rdata;
    assign FAN_DUTY_O   = s_q.duty;
    assign FLAG_O       = s_q.flag;
    assign PIN_A_O      = 1'b0;
    assign PIN_B_O      = 1'b0;
    assign PIN_A_OE_O   = s_q.drive & ~s_q.cfg4[BIT_PIN_SELECT]; // see [RL1]
    assign PIN_B_OE_O   = s_q.drive & s_q.cfg4[BIT_PIN_SELECT];  // see [RL1]
    assign ALERT_N_O    = ~(s_q.flag
                            & ~s_q.mask2[BIT_FLAG]); // see [RL14] [RL23]
    assign AUX_PIN_O    = 1'b0;
    assign AUX_PIN_OE_O = ~ALERT_N_O & s_q.cfg4[BIT_ALERT_AUX]; // see [RL21]

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (RST_I);

    a_pin_one_only: assert property (               // see [RL1]
        !(PIN_A_OE_O && PIN_B_OE_O))
        else $error("both throttle pins driven");
    a_full_speed_on: assert property (              // see [RL2]
        full_speed_on_throttle && running[0] |=> FAN_DUTY_O[0] == DUTY_FULL)
        else $error("running fan not forced to full duty");
    a_stopped_fan: assert property (                // see [RL3]
        !running[1] |=> FAN_DUTY_O[1] == $past(FAN_I[1].duty))
        else $error("stopped fan altered");
    a_no_override: assert property (                // see [RL4]
        !s_q.cfg3[BIT_FULL_SPEED] |=> FAN_DUTY_O[2] == $past(FAN_I[2].duty))
        else $error("fan changed with override off");
    a_timer_pause: assert property (                // see [RL5]
        !ext && !rd_timer |=> $stable(s_q.timer))
        else $error("timer moved while released");
    a_timer_sat: assert property (                  // see [RL6]
        s_q.timer == TIMER_FULL && !rd_timer |=> s_q.timer == TIMER_FULL)
        else $error("timer left full scale");
    a_first_assert: assert property (               // see [RL7]
        s_q.timer == RST_ZERO && ext |=> s_q.timer == TIMER_FIRST)
        else $error("bit 0 not set on first assertion");
    a_read_clear: assert property (                 // see [RL9]
        rd_timer && !ext |=> s_q.timer == RST_ZERO ##1 $stable(s_q.rdata))
        else $error("timer not cleared by read");
    a_read_assert: assert property (                // see [RL10]
        rd_timer && ext |=> s_q.timer == TIMER_FIRST)
        else $error("read during assertion did not restart");
    a_flag_set: assert property (                   // see [RL13]
        over |=> s_q.flag)
        else $error("limit exceeded without flag");
    a_mask_alert: assert property (                 // see [RL14]
        s_q.mask2[BIT_FLAG] |-> ALERT_N_O)
        else $error("masked alert asserted");
    a_drive_hold: assert property (                 // see [RL18]
        $changed(s_q.drive) |-> $past(|s_q.hot != |s_d.hot) ||
        $past(!s_q.cfg3[BIT_THR_EN]) || $past(TEMP_I[0].valid ||
        TEMP_I[1].valid || TEMP_I[2].valid || REG_REQ_I.wr))
        else $error("pin drive changed without measurement");

    // pin select and fan checks
    a_pin_a_sel: assert property (                  // see [RL1]
        PIN_A_OE_O |-> !s_q.cfg4[BIT_PIN_SELECT])
        else $error("pin a driven while b selected");
    a_pin_b_sel: assert property (                  // see [RL1]
        PIN_B_OE_O |-> s_q.cfg4[BIT_PIN_SELECT])
        else $error("pin b driven while a selected");
    a_full_speed_on_throttle_fan_one: assert property (              // see [RL2]
        full_speed_on_throttle && running[1] |=> FAN_DUTY_O[1] == DUTY_FULL)
        else $error("fan one not forced to full duty");
    a_full_speed_on_throttle_fan_two: assert property (              // see [RL2]
        full_speed_on_throttle && running[2] |=> FAN_DUTY_O[2] == DUTY_FULL)
        else $error("fan two not forced to full duty");
    a_stopped_fan_zero: assert property (           // see [RL3]
        !running[0] |=> FAN_DUTY_O[0] == $past(FAN_I[0].duty))
        else $error("stopped fan zero altered");

    // timer checks
    a_first_hold: assert property (                 // see [RL8]
        s_q.phase == PH_FIRST && !rd_timer |=> s_q.timer == TIMER_FIRST)
        else $error("timer left one before two ticks");
    a_half_step: assert property (                  // see [RL8]
        s_q.phase == PH_HALF && tick && !rd_timer
        |=> s_q.timer == TIMER_SECOND)
        else $error("timer not two after second tick");
    a_run_step: assert property (                   // see [RL6]
        s_q.phase == PH_RUN && tick && !rd_timer
        && s_q.timer != TIMER_FULL |=> s_q.timer == $past(s_q.timer) + 8'h01)
        else $error("timer did not step on tick");
    a_read_data: assert property (                  // see [RL9]
        rd_timer |=> REG_RDATA_O == $past(s_q.timer))
        else $error("timer read returned wrong value");
    a_presc_hold: assert property (                 // see [RL5]
        !ext && !rd_timer |=> $stable(s_q.presc))
        else $error("prescaler moved while released");
    a_tick_gate: assert property (                  // see [RL25]
        tick |-> ext)
        else $error("tick without assertion");
    a_presc_wrap: assert property (                 // see [RL25]
        tick |=> s_q.presc == '0)
        else $error("prescaler did not wrap on tick");

    // flag and alert checks
    a_reflag_zero: assert property (                // see [RL11]
        rd_timer && ext && s_q.limit == RST_ZERO && !REG_REQ_I.wr
        |=> ##1 s_q.flag)
        else $error("flag not set again after read");
    a_limit_write: assert property (                // see [RL12]
        REG_REQ_I.wr && REG_REQ_I.addr == OFS_LIMIT
        |=> s_q.limit == $past(REG_REQ_I.wdata))
        else $error("limit write lost");
    a_flag_cause: assert property (                 // see [RL13]
        !s_q.flag && !over |=> !s_q.flag)
        else $error("flag set without cause");
    a_flag_sticky: assert property (                // see [RL22]
        s_q.flag && !rd_status |=> s_q.flag)
        else $error("flag cleared without status read");
    a_alert_on: assert property (                   // see [RL23]
        s_q.flag && !s_q.mask2[BIT_FLAG] |-> !ALERT_N_O)
        else $error("unmasked flag without alert");
    a_aux_alert: assert property (                  // see [RL21]
        AUX_PIN_OE_O |-> s_q.cfg4[BIT_ALERT_AUX] && !ALERT_N_O)
        else $error("aux pin driven without alert");

    // over-temperature drive checks
    a_hot_set: assert property (                    // see [RL17]
        s_q.cfg[0][BIT_PIN_OUT_EN] && TEMP_I[0].valid
        && (TEMP_I[0].value > {s_q.crit[0], 2'b00})
        && s_q.cfg3[BIT_THR_EN] |=> s_q.drive)
        else $error("hot channel did not drive pin");
    a_no_enable: assert property (                  // see [RL20]
        !s_q.cfg[1][BIT_PIN_OUT_EN] |=> !s_q.hot[1])
        else $error("disabled channel marked hot");
    a_crit_write: assert property (                 // see [RL19]
        REG_REQ_I.wr && REG_REQ_I.addr == OFS_CRIT_R2
        |=> s_q.crit[2] == $past(REG_REQ_I.wdata))
        else $error("critical limit write lost");
    a_own_drive: assert property (                  // see [RL24]
        s_q.drive |-> !ext)
        else $error("own drive seen as input");
    a_sync_path: assert property (                  // see [RL24]
        $rose(ext) |-> $past(s_q.sync1))
        else $error("input bypassed synchroniser");

    c_full_speed: cover property (full_speed_on_throttle && running[0]);
    c_second_step: cover property (s_q.phase == PH_RUN);
    c_pin_drive: cover property ($rose(s_q.drive));
    c_flag_read: cover property (s_q.flag && rd_status && over);
    c_read_restart: cover property (rd_timer && ext);

endmodule // thermal_throttle_pin_monitor

// ### thermal_throttle_pin_monitor_tb_top.sv
// Purpose: self-checking bench for the throttle pin monitor
// Assumes: short prescaler so ticks are a few cycles long
// Notes:   expected values come from tmr, fexp and fixed constants
`timescale 1ns/10ps
module thermal_throttle_pin_monitor_tb_top;
    import throttle_monitor_pkg::*;
    localparam int TK = 8;
    logic             clk   = 1'b0;
    logic             rst   = 1'b1;
    logic             ha    = 1'b0;
    logic             hb    = 1'b0;
    reg_req_t         req   = '0;
    temp_meas_t [2:0] temp  = '0;
    fan_ctrl_t  [2:0] fan   = '0;
    logic [7:0]       rdata;
    logic [7:0]       d;
    logic [7:0]       lim;
    logic [2:0][7:0]  duty;
    logic             pa, pb, oa, ob, axe, al_n, flag;
    int               num_errors  = 0;
    int               checks_done = 0;

    initial begin
        forever #12.5 clk = ~clk;
    end

    thermal_throttle_pin_monitor #(.TICK_CYC(TK)) u_thermal_throttle_pin_monitor (
        .CORE_CLK_I(clk), .RST_I(rst), .REG_REQ_I(req), .REG_RDATA_O(rdata),
        .PIN_A_I(pa), .PIN_A_O(), .PIN_A_OE_O(oa),
        .PIN_B_I(pb), .PIN_B_O(), .PIN_B_OE_O(ob),
        .AUX_PIN_O(), .AUX_PIN_OE_O(axe), .ALERT_N_O(al_n),
        .TEMP_I(temp), .FAN_I(fan), .FAN_DUTY_O(duty), .FLAG_O(flag));

    throttle_source u_throttle_source (.hot_a_i(ha), .hot_b_i(hb),
        .oe_a_i(oa), .oe_b_i(ob), .pin_a_o(pa), .pin_b_o(pb));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] tmr(input int n);
        int t = n / TK;
        if (n <= 0) return 8'h00;
        return (t < 2) ? 8'h01 : ((t > 255) ? 8'hff : 8'(t));
    endfunction
    function automatic logic [7:0] fexp(input fan_ctrl_t f, input logic b, on);
        logic run = f.auto_mode ? f.above_start : (f.duty != 8'h00);
        return (b && on && run) ? DUTY_FULL : f.duty;
    endfunction
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        checks_done++;
        if (s !== e) begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        req <= '{a, 1'b1, 1'b0, v};
        @(posedge clk);
        req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        req <= '{a, 1'b0, 1'b1, 8'h00};
        @(posedge clk);
        req.rd <= 1'b0;
        @(posedge clk);
        #1 d = rdata;
    endtask
    task automatic hold(input logic b, input int h);
        @(posedge clk);
        if (b) hb <= 1'b1; else ha <= 1'b1;
        cyc(h);
        ha <= 1'b0;
        hb <= 1'b0;
        cyc(4);
    endtask
    task automatic tmp(input int c, input logic [9:0] v);
        @(posedge clk);
        temp[c] <= '{1'b1, v};
        @(posedge clk);
        temp[c].valid <= 1'b0;
        cyc(4);
    endtask
    task automatic complete_run();
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        fan_ctrl_t [2:0] f;
        logic            b;
        void'($urandom(97020));
        cyc(12);
        rst <= 1'b0;
        cyc(3);
        chk({7'h00, al_n}, 8'h01);
        rd(OFS_CFG3); chk(d, RST_CFG3);
        rd(8'h10); chk(d, 8'h00);
        lim = 8'($urandom);
        wr(OFS_LIMIT, lim); rd(OFS_LIMIT); chk(d, lim);
        wr(OFS_LIMIT, 8'hff);
        wr(OFS_TIMER, 8'h55);
        hold(1'b0, 6); rd(OFS_TIMER); chk(d, tmr(6));
        rd(OFS_TIMER); chk(d, 8'h00);
        for (int k = 2; k < 4; k++) begin
            hold(1'b0, k * TK + 4);
            rd(OFS_TIMER); chk(d, tmr(k * TK + 4));
        end
        hold(1'b0, 13); cyc(20); hold(1'b0, 13);
        rd(OFS_TIMER); chk(d, tmr(26));
        hold(1'b0, 260 * TK); cyc(20);
        rd(OFS_TIMER); chk(d, TIMER_FULL);
        // read in mid-assertion with a zero limit
        wr(OFS_LIMIT, 8'h00);
        @(posedge clk);
        ha <= 1'b1;
        cyc(28);
        rd(OFS_TIMER); chk(d, tmr(28));
        rd(OFS_TIMER); chk(d, TIMER_FIRST);
        rd(OFS_STATUS2); chk({7'h00, flag}, 8'h01);
        chk({7'h00, al_n}, 8'h00);
        wr(OFS_MASK2, 8'h20); cyc(2);
        chk({7'h00, al_n}, 8'h01);
        chk({7'h00, flag}, 8'h01);
        @(posedge clk);
        ha <= 1'b0;
        cyc(6);
        rd(OFS_TIMER); rd(OFS_STATUS2);
        chk({7'h00, flag}, 8'h00);
        wr(OFS_MASK2, 8'h00);
        wr(OFS_LIMIT, 8'h01);
        hold(1'b0, 12); chk({7'h00, flag}, 8'h00);
        hold(1'b0, 8); chk({7'h00, flag}, 8'h01);
        rd(OFS_STATUS2); chk({7'h00, al_n}, 8'h00);
        rd(OFS_TIMER); rd(OFS_STATUS2); cyc(2);
        chk({7'h00, al_n}, 8'h01);
        wr(OFS_LIMIT, 8'hff);
        wr(OFS_CFG4, 8'h02); hold(1'b0, 20);
        rd(OFS_TIMER); chk(d, 8'h00);
        hold(1'b1, 6); rd(OFS_TIMER); chk(d, 8'h01);
        wr(OFS_CFG3, 8'h00); hold(1'b1, 6);
        rd(OFS_TIMER); chk(d, 8'h00);
        wr(OFS_CFG4, 8'h00);
        // fan override, first pass holds the stopped-fan corners with the full-speed bit clear
        for (int i = 0; i < 6; i++) begin
            foreach (f[k]) f[k] = '{1'($urandom), 1'($urandom),
                ($urandom % 3 == 0) ? 8'h00 : 8'($urandom)};
            if (i == 0) f = {2'b00, 8'h00, 2'b10, 8'h80, 2'b00, 8'h01};
            b = i[0];
            wr(OFS_CFG3, b ? 8'h06 : 8'h02);
            @(posedge clk);
            ha <= 1'b1;
            fan <= f;
            cyc(6);
            foreach (f[k]) chk(duty[k], fexp(f[k], b, 1'b1));
            @(posedge clk);
            ha <= 1'b0;
            cyc(6);
            foreach (f[k]) chk(duty[k], fexp(f[k], b, 1'b0));
        end
        wr(OFS_CFG3, 8'h02);
        // over-temperature drive per channel
        for (int c = 0; c < 3; c++) begin
            lim = 8'($urandom % 255);
            wr(OFS_CRIT_R1 + 8'(c), lim); rd(OFS_TIMER);
            tmp(c, {lim, 2'b01}); chk({7'h00, oa}, 8'h00);
            wr(OFS_CFG_R1 + 8'(c), 8'h08);
            tmp(c, {lim, 2'b00}); chk({7'h00, oa}, 8'h00);
            tmp(c, {lim, 2'b01}); chk({7'h00, oa}, 8'h01);
            cyc(10); chk({7'h00, oa}, 8'h01);
            tmp(c, {lim, 2'b00}); chk({7'h00, oa}, 8'h00);
            wr(OFS_CFG_R1 + 8'(c), 8'h00); cyc(6);
            rd(OFS_TIMER); chk(d, 8'h00);
        end
        wr(OFS_LIMIT, 8'h00); hold(1'b0, 6);
        wr(OFS_CFG4, 8'h01); cyc(2); chk({7'h00, axe}, 8'h01);
        wr(OFS_CFG4, 8'h00); cyc(2); chk({7'h00, axe}, 8'h00);
        complete_run();
    end

    initial begin
        cyc(12000);
        num_errors++;
        complete_run();
    end
endmodule // thermal_throttle_pin_monitor_tb_top

// ### throttle_monitor_pkg.sv
// Purpose: constants and carrier types for the throttle pin monitor
// Assumes: 40 MHz core clock, 8-bit register port
// Notes:   temperatures carry two fraction bits (0.25 degree steps)
package throttle_monitor_pkg;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CFG_R1    = 8'h5f;
    localparam logic [7:0] OFS_CFG_LOC   = 8'h60;
    localparam logic [7:0] OFS_CFG_R2    = 8'h61;
    localparam logic [7:0] OFS_CRIT_R1   = 8'h6a;
    localparam logic [7:0] OFS_CRIT_LOC  = 8'h6b;
    localparam logic [7:0] OFS_CRIT_R2   = 8'h6c;
    localparam logic [7:0] OFS_STATUS2   = 8'h42;
    localparam logic [7:0] OFS_MASK2     = 8'h75;
    localparam logic [7:0] OFS_CFG3      = 8'h78;
    localparam logic [7:0] OFS_TIMER     = 8'h79;
    localparam logic [7:0] OFS_LIMIT     = 8'h7a;
    localparam logic [7:0] OFS_CFG4      = 8'h7d;
    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int         BIT_PIN_OUT_EN = 3;
    localparam int         BIT_FLAG       = 5;
    localparam int         BIT_THR_EN     = 1;
    localparam int         BIT_FULL_SPEED = 2;
    localparam int         BIT_PIN_SELECT = 1;
    localparam int         BIT_ALERT_AUX  = 0;
    localparam logic [7:0] RST_CFG3       = 8'h02;
    localparam logic [7:0] RST_ZERO       = 8'h00;
    localparam logic [7:0] TIMER_FULL     = 8'hff;
    localparam logic [7:0] TIMER_FIRST    = 8'h01;
    localparam logic [7:0] TIMER_SECOND   = 8'h02;
    localparam logic [7:0] DUTY_FULL      = 8'hff;
    localparam logic [7:0] DUTY_OFF       = 8'h00;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 25;
    localparam int TICK_TIME_NS  = 22_760_000;
    localparam int TICK_CYCLES   = TICK_TIME_NS / CLK_PERIOD_NS;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        PH_EMPTY = 4'b0001,
        PH_FIRST = 4'b0010,
        PH_HALF  = 4'b0100,
        PH_RUN   = 4'b1000
    } phase_t;
    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } reg_req_t;
    typedef struct packed {
        logic       valid;
        logic [9:0] value;
    } temp_meas_t;
    typedef struct packed {
        logic       auto_mode;
        logic       above_start;
        logic [7:0] duty;
    } fan_ctrl_t;
endpackage

// ### throttle_source.sv
// Purpose: far-side throttle source and open-drain pin resolution
// Assumes: both pins pulled up; any party pulling low wins
// Notes:   hot_x_i high means the source holds that pin low
`timescale 1ns/10ps
module throttle_source (
    // source requests and device drive
    input  wire logic hot_a_i,
    input  wire logic hot_b_i,
    input  wire logic oe_a_i,
    input  wire logic oe_b_i,
    // resolved pin levels
    output      logic pin_a_o,
    output      logic pin_b_o
);
    // pull-up unless either party pulls low
    assign pin_a_o = ~(hot_a_i | oe_a_i);
    assign pin_b_o = ~(hot_b_i | oe_b_i);
endmodule // throttle_source
